// [shared/seq_defines.svh]
/*
  Offsets, field positions, reset values and timing counts of the
  flyback startup and survival sequencer.
  Assumes a 100 MHz sequencer clock; nothing else is assumed.
*/
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// ==========================================================
// clock and timing
`define CLK_PERIOD_NS 10
`define AUX_MIN_NS 10000
`define AUX_MIN_CYC ((`AUX_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MIN_NS 2200
`define WAKE_MIN_CYC ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SS_TMO_NS 700000
`define SS_TMO_CYC (`SS_TMO_NS / `CLK_PERIOD_NS)

// ==========================================================
// gate pulse shapes, in clock cycles
`define LS_ON_CYC 30
`define DEAD_CYC 5
`define HS_ON_CYC 20
`define HS_LONG_CYC 200
`define GAP_CYC 40

// ==========================================================
// pulse counts
`define SM1_PULSES 5
`define SV_MIN_FIRST 9
`define SV_MIN_LATER 3

// ==========================================================
// register map
`define ADDR_CTRL 12'h000
`define ADDR_STAT 12'h004
`define CTRL_HOLD_BIT 0
`define CTRL_RST 1'b0

`endif

// [shared/seq_pkg.sv]
/*
  Types of the flyback startup and survival sequencer.
  Assumes seq_defines.svh on the include path.
*/
`include "seq_defines.svh"

package seq_pkg;

  // ==========================================================
  // sequencing states
  typedef enum logic [2:0] {
    ST_CHARGE,
    ST_REF,
    ST_AUX,
    ST_WAKE,
    ST_RUN,
    ST_FAULT
  } state_t;

  typedef enum logic [2:0] {
    P_IDLE,
    P_LS,
    P_DEAD,
    P_HS,
    P_GAP
  } phase_t;

  typedef enum logic [1:0] {
    LVL_SM1,
    LVL_SM2,
    LVL_MAX
  } lvl_t;

  typedef logic [16:0] tmr_t;

  // ==========================================================
  // comparator flags, all asynchronous to the clock
  typedef struct packed {
    logic vdd_1v8;
    logic vdd_on;
    logic ref_ok;
    logic aux_13v;
    logic sw_pgood;
    logic vs_028;
    logic vs_050;
    logic bin_on;
    logic bin_off;
    logic vdd_low;
    logic fb_stop;
  } flags_t;

  // ==========================================================
  // whole sequencer state
  typedef struct packed {
    state_t st;
    phase_t ph;
    tmr_t tmr;
    logic [7:0] ptmr;
    logic [2:0] ls_cnt;
    logic [3:0] sv_cnt;
    logic sv_done1;
    logic sv_act;
    logic vs_smp;
    lvl_t lvl;
    logic path_off;
    logic lowr;
    logic refen;
    logic auxc;
    logic wake;
    logic s13;
    logic ls;
    logic hs;
    logic boost;
    logic fault;
    logic hold;
    logic [31:0] rdata;
  } seq_t;

endpackage : seq_pkg

// [src/flag_sync.sv]
/*
  Two-flop synchroniser for a vector of independent level flags.
  Assumes each bit is a slow level; no bus coherency is given.
*/
`timescale 1ns/1ps
`default_nettype none

module flag_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // flags
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;

endmodule : flag_sync

`default_nettype wire

// [src/startup_seq.sv]
/*
  Startup, soft-start and supply-survival sequencer of an active-clamp
  flyback controller, with an APB register slave.
  Assumes analog levels arrive as comparator flags, the reset comes
  from undervoltage lockout, and external drivers follow the gates.
*/
// Behaviour
// - below 1.8 V supply the charge path stays high-resistance.
// - above 1.8 V supply the charge path switches to low resistance.
// - at 17 V turn-on both startup power-path switches open.
// - aux rail at 13 V within 10 us raises open-pin fault.
// - aux rail settled without fault raises driver wake, enters wake state.
// - at least 2.2 us from wake to first low-side pulse; rail switch on.
// - first low-side pulse waits for switched rail power-good.
// - soft-start peak threshold is 0.2 V level, then 0.5 V level.
// - outside survival, level one blocks high-side below 0.28 V; holds five pulses.
// - level two only after sense above 0.28 V and five pulses.
// - 0.7 ms timeout forces level two anyway.
// - boost off while bias input below 2.2 V; on above it only in run state.
// - enabled boost regulates supply toward 18.5 V.
// - sense above 0.5 V releases threshold to maximum.
// - line-sense pulse applied while low-side gate is high.
// - bias input above 15 V stops boost switching.
// - survival only while feedback stops switching on overshoot.
// - survival pulses unlimited below 13 V; above 13 V stop once 9 (first event) or 3 (later) are done.
// - feedback resuming switching ends survival, normal mode resumes.
// - survival burst is low-side train then one long high-side pulse.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.svh"

module startup_seq
  import seq_pkg::*;
#(
  parameter tmr_t SS_TMO_CYC = tmr_t'(`SS_TMO_CYC)
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // comparator flags
  input wire flags_t FLAGS_I,
  // power path
  output logic STARTUP_PATH_ON_O,
  output logic STARTUP_LOW_RES_O,
  output logic REF_EN_O,
  output logic AUX_RAIL_CONNECT_O,
  output logic SW_RAIL_EN_O,
  output logic DRIVER_WAKE_O,
  // gates
  output logic LOW_SIDE_GATE_CMD_O,
  output logic HIGH_SIDE_GATE_CMD_O,
  output logic LINE_SENSE_PULSE_O,
  output lvl_t PEAK_LEVEL_O,
  // bias and status
  output logic BOOST_EN_O,
  output logic SURVIVAL_O,
  output logic OPEN_PIN_FAULT_O
);

  localparam tmr_t AUX_MIN = tmr_t'(`AUX_MIN_CYC);
  localparam tmr_t WAKE_MIN = tmr_t'(`WAKE_MIN_CYC);
  localparam logic [7:0] LS_ON = 8'(`LS_ON_CYC);
  localparam logic [7:0] DEAD = 8'(`DEAD_CYC);
  localparam logic [7:0] HS_ON = 8'(`HS_ON_CYC);
  localparam logic [7:0] HS_LONG = 8'(`HS_LONG_CYC);
  localparam logic [7:0] GAP = 8'(`GAP_CYC);
  localparam logic [2:0] SM1_N = 3'(`SM1_PULSES);
  localparam logic [3:0] SV_FIRST = 4'(`SV_MIN_FIRST);
  localparam logic [3:0] SV_LATER = 4'(`SV_MIN_LATER);

  seq_t q;
  seq_t d;
  flags_t f;
  logic [3:0] sv_min;
  logic [7:0] hs_len;
  logic apb_ok;

  // ==========================================================
  // flag synchronisers
  flag_sync #(
    .W($bits(flags_t))
  ) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(FLAGS_I),
    .q_o(f)
  );

  assign sv_min = q.sv_done1 ? SV_LATER : SV_FIRST;
  assign hs_len = q.sv_act ? HS_LONG : HS_ON;
  assign apb_ok = (PADDR_I == `ADDR_CTRL) || (PADDR_I == `ADDR_STAT);

  // ==========================================================
  // sequencer
  always_comb begin
    d = q;
    case (q.st)
      ST_CHARGE: begin
        d.path_off = 1'b0;
        d.lowr = f.vdd_1v8;
        if (f.vdd_on) begin
          d.path_off = 1'b1;
          d.lowr = 1'b0;
          d.refen = 1'b1;
          d.st = ST_REF;
        end
      end
      ST_REF: begin
        if (f.ref_ok) begin
          d.auxc = 1'b1;
          d.tmr = '0;
          d.st = ST_AUX;
        end
      end
      ST_AUX: begin
        if (q.tmr != '1) begin
          d.tmr = q.tmr + 1'b1;
        end
        if (f.aux_13v) begin
          // a rail that settles this fast has no capacitor on it
          if (q.tmr < AUX_MIN) begin
            d.fault = 1'b1;
            d.auxc = 1'b0;
            d.refen = 1'b0;
            d.st = ST_FAULT;
          end else begin
            d.wake = 1'b1;
            d.s13 = 1'b1;
            d.tmr = '0;
            d.st = ST_WAKE;
          end
        end
      end
      ST_WAKE: begin
        if (q.tmr != '1) begin
          d.tmr = q.tmr + 1'b1;
        end
        if (q.tmr >= WAKE_MIN - 1'b1 && f.sw_pgood && !q.hold) begin
          d.st = ST_RUN;
          d.tmr = '0;
          d.lvl = LVL_SM1;
          d.ph = P_LS;
          d.ptmr = '0;
          d.ls = 1'b1;
        end
      end
      ST_RUN: begin
        if (q.tmr != '1) begin
          d.tmr = q.tmr + 1'b1;
        end
        if (q.lvl == LVL_SM1) begin
          if ((q.ls_cnt == SM1_N && q.vs_smp)
              || q.tmr >= SS_TMO_CYC - 1'b1) begin
            d.lvl = LVL_SM2;
          end
        end
        if (f.vs_050) begin
          d.lvl = LVL_MAX;
        end
        // enable of the 18.5 V supply regulation loop
        d.boost = f.bin_on && !f.bin_off;
        if (q.ph != P_IDLE) begin
          d.ptmr = q.ptmr + 1'b1;
        end
        case (q.ph)
          P_IDLE: begin
            if (!f.fb_stop) begin
              d.sv_act = 1'b0;
              d.sv_cnt = '0;
              if (!q.hold) begin
                d.ph = P_LS;
                d.ptmr = '0;
                d.ls = 1'b1;
              end
            end else if (f.vdd_low || q.sv_act) begin
              d.sv_act = 1'b1;
              d.ph = P_LS;
              d.ptmr = '0;
              d.ls = 1'b1;
            end
          end
          P_LS: begin
            if (q.ptmr >= LS_ON - 1'b1) begin
              d.ls = 1'b0;
              d.vs_smp = f.vs_028;
              if (q.ls_cnt != SM1_N) begin
                d.ls_cnt = q.ls_cnt + 1'b1;
              end
              if (q.sv_act && q.sv_cnt != 4'hf) begin
                d.sv_cnt = q.sv_cnt + 1'b1;
              end
              d.ph = P_DEAD;
              d.ptmr = '0;
            end
          end
          P_DEAD: begin
            if (q.ptmr >= DEAD - 1'b1) begin
              d.ptmr = '0;
              d.ph = P_GAP;
              if (q.sv_act) begin
                // long high-side pulse closes the burst once back up
                if (q.sv_cnt >= sv_min && !f.vdd_low) begin
                  d.hs = 1'b1;
                  d.ph = P_HS;
                end
              end else if (!(q.lvl == LVL_SM1 && !q.vs_smp)) begin
                d.hs = 1'b1;
                d.ph = P_HS;
              end
            end
          end
          P_HS: begin
            if (q.ptmr >= hs_len - 1'b1) begin
              d.hs = 1'b0;
              if (q.sv_act) begin
                d.sv_act = 1'b0;
                d.sv_done1 = 1'b1;
                d.sv_cnt = '0;
              end
              d.ph = P_GAP;
              d.ptmr = '0;
            end
          end
          P_GAP: begin
            if (q.ptmr >= GAP - 1'b1) begin
              d.ph = P_IDLE;
              d.ptmr = '0;
            end
          end
          default: begin
            d.ph = P_IDLE;
          end
        endcase
      end
      ST_FAULT: begin
        // latched until undervoltage lockout resets the device
        d.fault = 1'b1;
        d.path_off = 1'b1;
        d.lowr = 1'b0;
      end
      default: begin
        d.st = ST_CHARGE;
      end
    endcase

    // register slave: read data captured in the setup cycle
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      d.rdata = '0;
      if (PADDR_I == `ADDR_CTRL) begin
        d.rdata[`CTRL_HOLD_BIT] = q.hold;
      end else if (PADDR_I == `ADDR_STAT) begin
        d.rdata[7:0] = {q.fault, q.sv_act, q.lvl, q.ls_cnt == SM1_N,
                        q.st};
      end
    end
    if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `ADDR_CTRL) begin
      d.hold = PWDATA_I[`CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA_O = q.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !apb_ok;
  assign STARTUP_PATH_ON_O = !q.path_off;
  assign STARTUP_LOW_RES_O = q.lowr;
  assign REF_EN_O = q.refen;
  assign AUX_RAIL_CONNECT_O = q.auxc;
  assign SW_RAIL_EN_O = q.s13;
  assign DRIVER_WAKE_O = q.wake;
  assign LOW_SIDE_GATE_CMD_O = q.ls;
  assign HIGH_SIDE_GATE_CMD_O = q.hs;
  assign LINE_SENSE_PULSE_O = q.ls;
  assign PEAK_LEVEL_O = q.lvl;
  assign BOOST_EN_O = q.boost;
  assign SURVIVAL_O = q.sv_act;
  assign OPEN_PIN_FAULT_O = q.fault;

  // ==========================================================
  // checks
  logic [8:0] wake_age;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_age <= '0;
    end else if (!q.wake) begin
      wake_age <= '0;
    end else if (wake_age != '1) begin
      wake_age <= wake_age + 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence early_rail_s;
    q.st == ST_AUX && f.aux_13v && q.tmr < AUX_MIN;
  endsequence

  sequence fault_held_s;
    q.st == ST_FAULT && q.fault ##1 q.st == ST_FAULT && !q.wake;
  endsequence

  sequence sv_hs_start_s;
    $rose(q.hs) && q.sv_act;
  endsequence

  charge_high_res_a: assert property (
    !f.vdd_1v8 |=> !q.lowr)
    else $error("charge path left high resistance too early");

  charge_low_res_a: assert property (
    (q.st == ST_CHARGE && f.vdd_1v8 && !f.vdd_on) |=> q.lowr)
    else $error("charge path not switched to low resistance");

  path_open_a: assert property (
    (q.st == ST_CHARGE && f.vdd_on) |=> q.path_off && q.refen)
    else $error("startup path not opened at turn-on");

  aux_after_ref_a: assert property (
    $rose(q.auxc) |-> q.refen && $past(q.st) == ST_REF)
    else $error("aux rail connected before reference");

  open_pin_a: assert property (
    early_rail_s |=> fault_held_s)
    else $error("early aux rail did not raise fault");

  wake_gap_a: assert property (
    ($rose(q.ls) && q.sv_cnt == '0 && q.ls_cnt == '0)
      |-> wake_age >= 9'(`WAKE_MIN_CYC) && q.s13)
    else $error("first low-side pulse too soon after wake");

  pgood_wait_a: assert property (
    (q.st == ST_WAKE && !f.sw_pgood) |=> q.st == ST_WAKE && !q.ls)
    else $error("low-side pulse without switched rail power-good");

  sm1_hs_block_a: assert property (
    ($rose(q.hs) && !q.sv_act) |-> !(q.lvl == LVL_SM1 && !q.vs_smp))
    else $error("high-side pulse at level one with low sense");

  level_step_a: assert property (
    ($past(q.lvl) == LVL_SM1 && q.lvl == LVL_SM2)
      |-> ($past(q.ls_cnt) == SM1_N && $past(q.vs_smp))
        || $past(q.tmr) >= SS_TMO_CYC - 1'b1)
    else $error("level two reached without its cause");

  boost_on_a: assert property (
    (q.st == ST_RUN && f.bin_on && !f.bin_off) |=> q.boost)
    else $error("boost not enabled above bias threshold");

  boost_off_a: assert property (
    (!f.bin_on || f.bin_off) |=> !q.boost)
    else $error("boost running outside its input window");

  survival_cause_a: assert property (
    $rose(q.sv_act) |-> $past(f.fb_stop))
    else $error("survival entered without feedback stop");

  survival_burst_a: assert property (
    sv_hs_start_s |-> q.sv_cnt >= sv_min ##1 q.hs [*8])
    else $error("survival high-side pulse too early or short");

endmodule : startup_seq

`default_nettype wire

// [verification/power_stage_model.sv]
/*
  Far-side model: power stage rails settling behind the sequencer's
  switches, and the external high-side gate driver.
  Assumes the sequencer's clock and undervoltage reset.
*/
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sequencer outputs
  input wire logic ref_en_i,
  input wire logic aux_conn_i,
  input wire logic sw_rail_en_i,
  input wire logic wake_i,
  input wire logic hs_cmd_i,
  // settling times in cycles
  input wire logic [15:0] aux_dly_i,
  input wire logic [15:0] pg_dly_i,
  // comparator levels and driver state
  output logic ref_ok_o,
  output logic aux_13v_o,
  output logic sw_pgood_o,
  output logic hs_on_o
);
  // ==========================================================
  // rails
  localparam int REF_CYC = 50;
  // driver power-on delay kept well below 1000 cycles
  localparam int DRV_CYC = 300;
  int rc;
  int ac;
  int pc;
  int dc;

  // a rail whose switch opens collapses, so its level drops at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc <= 0;
      ac <= 0;
      pc <= 0;
      dc <= 0;
      ref_ok_o <= 1'h0;
      aux_13v_o <= 1'h0;
      sw_pgood_o <= 1'h0;
      hs_on_o <= 1'h0;
    end else begin
      rc <= ref_en_i ? rc + 1 : 0;
      ac <= aux_conn_i ? ac + 1 : 0;
      pc <= sw_rail_en_i ? pc + 1 : 0;
      dc <= wake_i ? dc + 1 : 0;
      ref_ok_o <= ref_en_i && rc >= REF_CYC;
      aux_13v_o <= aux_conn_i && ac >= int'(aux_dly_i);
      sw_pgood_o <= sw_rail_en_i && pc >= int'(pg_dly_i);
      hs_on_o <= hs_cmd_i && dc >= DRV_CYC;
    end
  end
endmodule : power_stage_model

`default_nettype wire

// [verification/testbench.sv]
/*
  Self-checking bench of the startup and survival sequencer.
  Assumes power_stage_model and seq_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import seq_pkg::*;
  localparam int TMO = 2000;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} row_t;
  row_t rows[8] = '{'{1'h1, 12'h000, 32'h1, 1'h0},
    '{1'h0, 12'h000, 32'h1, 1'h0}, '{1'h1, 12'h004, 32'hff, 1'h0},
    '{1'h0, 12'h004, 32'h0, 1'h0}, '{1'h1, 12'h00c, 32'hff, 1'h1},
    '{1'h0, 12'h00c, 32'h0, 1'h1}, '{1'h1, 12'h000, 32'h0, 1'h0},
    '{1'h0, 12'h000, 32'h0, 1'h0}};
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  flags_t tbf, fl;
  lvl_t lvl;
  logic path, lowr, refen, auxc, swen, wake, ls, hs, lsp, boost, surv, flt;
  logic ref_ok, aux_ok, pg, hs_on;
  // monitor state is owned by the gate monitor alone
  logic ls_q = 1'h0, hs_seen = 1'h0;
  logic [15:0] aux_dly, pg_dly;
  int err_count, comparisons, n, l0, h0;
  int ls_n = 0, hs_n = 0, hs_run = 0, hs_last = 0;

  always_comb begin
    fl = tbf;
    fl.ref_ok = ref_ok;
    fl.aux_13v = aux_ok;
    fl.sw_pgood = pg;
  end

  startup_seq #(.SS_TMO_CYC(tmr_t'(TMO))) dut (.CLK_I(clk),
    .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FLAGS_I(fl),
    .STARTUP_PATH_ON_O(path), .STARTUP_LOW_RES_O(lowr), .REF_EN_O(refen),
    .AUX_RAIL_CONNECT_O(auxc), .SW_RAIL_EN_O(swen), .DRIVER_WAKE_O(wake),
    .LOW_SIDE_GATE_CMD_O(ls), .HIGH_SIDE_GATE_CMD_O(hs),
    .LINE_SENSE_PULSE_O(lsp), .PEAK_LEVEL_O(lvl), .BOOST_EN_O(boost),
    .SURVIVAL_O(surv), .OPEN_PIN_FAULT_O(flt));

  power_stage_model model (.clk_i(clk), .rst_n_i(rst_n), .ref_en_i(refen),
    .aux_conn_i(auxc), .sw_rail_en_i(swen), .wake_i(wake), .hs_cmd_i(hs),
    .aux_dly_i(aux_dly), .pg_dly_i(pg_dly), .ref_ok_o(ref_ok),
    .aux_13v_o(aux_ok), .sw_pgood_o(pg), .hs_on_o(hs_on));

  // ==========================================================
  // clock, gate monitor, helpers
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    ls_q <= ls;
    if (ls && !ls_q) ls_n <= ls_n + 1;
    if (hs_on) hs_seen <= 1'h1;
    if (hs) hs_run <= hs_run + 1;
    else if (hs_run > 0) begin
      hs_last <= hs_run;
      hs_n <= hs_n + 1;
      hs_run <= 0;
    end
  end

  always @(negedge clk) if (rst_n) chk("line_sense", ls, lsp);

  task automatic chk(input string nm, input logic [31:0] x, g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, x, g);
    end
  endtask : chk

  task automatic chk_min(input string nm, input int g, input int m);
    comparisons++;
    if (g < m) begin
      err_count++;
      $display("CHECK FAILED %s expected >=%0d seen %0d", nm, m, g);
    end
  endtask : chk_min

  task automatic wait_n(input int k);
    repeat (k) @(negedge clk);
  endtask : wait_n

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    tbf <= '0;
    wait_n(10);
    chk("reset_outs", 11'h400, {path, lowr, refen, auxc, swen, wake, ls,
      hs, boost, surv, flt});
    @(posedge clk);
    rst_n <= 1'h1;
  endtask : do_reset

  // brings the supply up; stops at wake or fault
  task automatic start(input logic [15:0] ad, pd);
    aux_dly <= ad;
    pg_dly <= pd;
    wait_n(20);
    chk("low_res", 1'h0, lowr);
    @(posedge clk);
    tbf.vdd_1v8 <= 1'h1;
    // two edges of synchroniser: still high resistance after the second
    wait_n(3);
    chk("low_res_sync", 1'h0, lowr);
    wait_n(3);
    chk("low_res", 1'h1, lowr);
    @(posedge clk);
    tbf.vdd_on <= 1'h1;
    for (n = 0; n < 20 && refen !== 1'h1; n++) @(negedge clk);
    chk("path_on", 1'h0, path);
    chk("aux_conn", 1'h0, auxc);
    for (n = 0; n < 1600 && wake !== 1'h1 && flt !== 1'h1; n++)
      @(negedge clk);
  endtask : start

  task automatic sv_event(input int k, input int mn);
    l0 = ls_n;
    h0 = hs_n;
    @(posedge clk);
    tbf.vdd_low <= 1'h1;
    for (n = 0; n < 200 && surv !== 1'h1; n++) @(negedge clk);
    chk("survival", 1'h1, surv);
    for (n = 0; n < 3000 && ls_n < l0 + k; n++) @(negedge clk);
    @(posedge clk);
    tbf.vdd_low <= 1'h0;
    for (n = 0; n < 3000 && surv === 1'h1; n++) @(negedge clk);
    wait_n(3);
    chk_min("sv_pulses", ls_n - l0, mn);
    chk("sv_hs_width", 200, hs_last);
    chk("sv_hs_count", h0 + 1, hs_n);
  endtask : sv_event

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    {rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    tbf = '0;
    {aux_dly, pg_dly} = '0;
    {err_count, comparisons} = '0;
    do_reset();
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", rows[i].e, e);
      if (!rows[i].w) chk("prdata", rows[i].d, rd);
    end
    $display("done: registers");
    start(16'h4b0, 16'h64);
    chk("aux_conn", 1'h1, auxc);
    chk("wake", 1'h1, wake);
    chk("fault", 1'h0, flt);
    chk("sw_rail", 1'h1, swen);
    for (n = 0; n < 2000 && ls !== 1'h1; n++) @(negedge clk);
    chk_min("wake_to_ls", n, 220);
    chk("level", LVL_SM1, lvl);
    for (n = 0; n < 2000 && ls_n < 3; n++) @(negedge clk);
    chk("hs_count", 0, hs_n);
    @(posedge clk);
    tbf.vs_028 <= 1'h1;
    for (n = 0; n < 500 && ls_n < 4; n++) @(negedge clk);
    wait_n(40);
    chk("level", LVL_SM1, lvl);
    for (n = 0; n < 400 && lvl === LVL_SM1; n++) @(negedge clk);
    chk("level", LVL_SM2, lvl);
    chk_min("ls_before_sm2", ls_n, 5);
    @(posedge clk);
    tbf.vs_050 <= 1'h1;
    wait_n(5);
    chk("level", LVL_MAX, lvl);
    chk("boost", 1'h0, boost);
    @(posedge clk);
    tbf.bin_on <= 1'h1;
    wait_n(5);
    chk("boost", 1'h1, boost);
    @(posedge clk);
    tbf.bin_off <= 1'h1;
    wait_n(5);
    chk("boost", 1'h0, boost);
    $display("done: startup");
    @(posedge clk);
    tbf.fb_stop <= 1'h1;
    wait_n(200);
    l0 = ls_n;
    wait_n(300);
    chk("idle_pulses", l0, ls_n);
    chk("survival", 1'h0, surv);
    sv_event(2, 9);
    sv_event(12, 12);
    sv_event(1, 3);
    h0 = hs_n;
    @(posedge clk);
    tbf.fb_stop <= 1'h0;
    for (n = 0; n < 600 && hs_n < h0 + 2; n++) @(negedge clk);
    chk("hs_width", 20, hs_last);
    chk("survival", 1'h0, surv);
    chk("hs_driver", 1'h1, hs_seen);
    $display("done: survival");
    do_reset();
    start(16'h64, 16'h64);
    chk("fault", 1'h1, flt);
    chk("wake", 1'h0, wake);
    apb(1'h0, 12'h004, 32'h0);
    chk("stat_fault", 1'h1, rd[7]);
    $display("done: open pin");
    do_reset();
    h0 = hs_n;
    start(16'h4b0, 16'h190);
    chk("wake", 1'h1, wake);
    for (n = 0; n < 2000 && ls !== 1'h1; n++) @(negedge clk);
    chk_min("pgood_to_ls", n, 400);
    for (n = 0; n < TMO + 500 && lvl === LVL_SM1; n++) @(negedge clk);
    chk("level", LVL_SM2, lvl);
    chk("hs_count", h0, hs_n);
    $display("done: timeout");
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
